// ---- cc_console.sv ----
// console and cassette control: panel buttons, lamps, run/halt sequencing
// and system-mode tape word assembly, with an APB register slave
// assumes processor decode logic on ref_clk_i; panel and drive pins async
`timescale 1ns/1ps
module cc_console
    import cc_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DB_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [CTL_W-1:0] panel_i,
    input wire logic [WORD_W-1:0] data_sw_i,
    output logic lamp_intr_o,
    output logic lamp_test_o,
    output logic lamp_state_o,
    output logic lamp_run_o,
    output logic lamp_mode_o,
    output logic lamp_leader_o,
    output logic [WORD_W-1:0] lamp_mex_o,
    input wire logic [WORD_W-1:0] main_exchange_bus_i,
    input wire logic micro_done_i,
    input wire logic fetch_req_i,
    input wire logic cassette_control_micro_i,
    input wire logic cassette_run_arg_i,
    input wire logic tape_word_read_i,
    output logic run_o,
    output logic load_next_o,
    output logic force_halt_o,
    output logic clear_o,
    output logic tape_to_micro_o,
    output logic fetch_stall_o,
    output logic tape_micro_execution_mode_o,
    output logic [MSRC_W-1:0] micro_src_o,
    output logic [WORD_W-1:0] tape_word_o,
    output logic tape_word_valid_o,
    output logic [WORD_W-1:0] console_data_o,
    output logic console_data_en_o,
    input wire logic tape_bit_clk_i,
    input wire logic tape_bit_i,
    input wire logic tape_leader_detected_i,
    input wire logic io_run_i,
    input wire logic io_rewind_i,
    output logic drive_owner_io_o,
    output logic drive_run_o,
    output logic drive_rewind_o
);

    typedef struct packed {
        cc_run_t run;
        logic console_interrupt_bit;
        logic state_bit;
        logic [MSRC_W-1:0] msrc;
        logic tape_run;
        logic rewind;
        logic [2:0] tclk_sync;
        logic [1:0] tbit_sync;
        logic [1:0] lead_sync;
        logic [CW_W-1:0] cw;
        logic [CNT_W-1:0] bit_cnt;
        logic [CNT_W-1:0] nib_cnt;
        logic [WORD_W-1:0] asm_word;
        logic [WORD_W-1:0] tape_word;
        logic tape_valid;
        logic overrun;
        logic corrected;
        logic [CTL_W-1:0] ctl_prev;
        logic clear_p;
        logic load_next_p;
        logic force_p;
        logic to_micro_p;
        logic [WORD_W-1:0] main_exchange_bus;
        logic [31:0] prdata;
    } cc_state_t;

    cc_state_t s_r;
    cc_state_t s_nxt;

    logic [CTL_W-1:0] ctl;
    logic [CTL_W-1:0] press;
    logic [WORD_W-1:0] data_sw;
    logic io_mode;
    logic mtr_mode;
    logic halted;
    logic intr_press;
    logic clr_press;
    logic start_press;
    logic halt_press;
    logic force_req;
    logic rewind_ok;
    logic fetch_go;
    logic word_done;
    logic apb_wr;
    logic [MSRC_W-1:0] panel_src;

    function automatic logic cc_mapped(input logic [ADDR_W-1:0] a);
        cc_mapped = (a == OFF_CTRL) || (a == OFF_MSRC) ||
                    (a == OFF_STAT) || (a == OFF_TAPE) ||
                    (a == OFF_SWITCH);
    endfunction

    cc_debounce #(
        .W(CTL_W),
        .CNT(DEBOUNCE_CYCLES)
    ) u_db_ctl (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .raw_i(panel_i),
        .stable_o(ctl)
    );

    cc_debounce #(
        .W(WORD_W),
        .CNT(DEBOUNCE_CYCLES)
    ) u_db_data (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .raw_i(data_sw_i),
        .stable_o(data_sw)
    );

    assign press = ctl & ~s_r.ctl_prev;
    assign intr_press = press[BTN_INTR_OP] | press[BTN_INTR_DM];
    assign clr_press = press[BTN_CLR_OP] | press[BTN_CLR_DM];
    assign start_press = press[BTN_START_OP] | press[BTN_START_DM];
    assign halt_press = press[BTN_HALT];
    assign force_req = (halt_press & (ctl[BTN_CLR_OP] | ctl[BTN_CLR_DM])) |
                       (clr_press & ctl[BTN_HALT]);
    assign io_mode = ctl[SW_IO];
    // submode selector only live in system mode
    assign mtr_mode = ~io_mode & ctl[SW_MTR];
    assign halted = (s_r.run == RS_HALT);
    assign panel_src = ctl[SW_SRC_LO +: MSRC_W];
    assign rewind_ok = press[BTN_REWIND] & ~io_mode & ~s_r.tape_run;
    assign fetch_go = mtr_mode & ~halted & fetch_req_i & s_r.tape_valid;
    assign apb_wr = psel_i & penable_i & pwrite_i;
    assign word_done = s_r.tape_run & s_r.tclk_sync[1] & ~s_r.tclk_sync[2] &
                       (s_r.bit_cnt == CW_LAST) & (s_r.nib_cnt == NIB_LAST);

    always_comb
    begin
        logic [CW_W-1:0] cw_new;
        logic [31:0] rd;
        logic [31:0] stat;
        logic consume;
        logic corr_set;
        cw_new = {s_r.tbit_sync[1], s_r.cw[CW_W-1:1]};
        rd = '0;
        stat = '0;
        consume = tape_word_read_i | fetch_go;
        corr_set = 1'b0;
        s_nxt = s_r;
        s_nxt.ctl_prev = ctl;
        s_nxt.tclk_sync = {s_r.tclk_sync[1:0], tape_bit_clk_i};
        s_nxt.tbit_sync = {s_r.tbit_sync[0], tape_bit_i};
        s_nxt.lead_sync = {s_r.lead_sync[0], tape_leader_detected_i};
        // exchange bus shown at all times
        s_nxt.main_exchange_bus = main_exchange_bus_i;
        s_nxt.clear_p = clr_press;
        s_nxt.load_next_p = 1'b0;
        s_nxt.force_p = force_req;
        s_nxt.to_micro_p = fetch_go;

        unique case (s_r.run)
            RS_HALT:
            begin
                if (start_press && !force_req)
                begin
                    s_nxt.run = ctl[SW_SINGLE] ? RS_STEP : RS_RUN;
                end
            end
            RS_RUN:
            begin
                if (halt_press)
                begin
                    s_nxt.run = RS_STOP;
                end
            end
            RS_STOP, RS_STEP:
            begin
                if (micro_done_i)
                begin
                    s_nxt.run = RS_HALT;
                    s_nxt.load_next_p = ~mtr_mode;
                end
            end
        endcase
        if (force_req)
        begin
            s_nxt.run = RS_HALT;
            s_nxt.load_next_p = 1'b0;
        end

        if (cassette_control_micro_i && !io_mode)
        begin
            s_nxt.tape_run = cassette_run_arg_i;
        end
        if (start_press && halted && mtr_mode)
        begin
            s_nxt.tape_run = 1'b1;
        end
        if (io_mode)
        begin
            s_nxt.tape_run = 1'b0;
        end
        if (rewind_ok)
        begin
            s_nxt.rewind = 1'b1;
        end
        else if (s_r.lead_sync[1] || io_mode)
        begin
            s_nxt.rewind = 1'b0;
        end

        if (!s_r.tape_run)
        begin
            s_nxt.bit_cnt = '0;
            s_nxt.nib_cnt = '0;
        end
        else if (s_r.tclk_sync[1] && !s_r.tclk_sync[2])
        begin
            s_nxt.cw = cw_new;
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
            if (s_r.bit_cnt == CW_LAST)
            begin
                s_nxt.bit_cnt = '0;
                s_nxt.asm_word = {s_r.asm_word[WORD_W-NIB_W-1:0],
                                  cc_fix_nibble(cw_new)};
                if (cc_syndrome(cw_new) != '0)
                begin
                    s_nxt.corrected = 1'b1;
                    corr_set = 1'b1;
                end
                s_nxt.nib_cnt = s_r.nib_cnt + 1'b1;
                if (s_r.nib_cnt == NIB_LAST)
                begin
                    s_nxt.nib_cnt = '0;
                end
            end
        end
        if (consume)
        begin
            s_nxt.tape_valid = 1'b0;
        end
        // new word beats the consume of the old one
        if (word_done)
        begin
            s_nxt.tape_word = {s_r.asm_word[WORD_W-NIB_W-1:0],
                               cc_fix_nibble(cw_new)};
            s_nxt.tape_valid = 1'b1;
        end
        if (word_done && s_r.tape_valid && !consume)
        begin
            s_nxt.overrun = 1'b1;
        end

        // register writes; sticky flags keep a same-cycle set
        if (apb_wr && paddr_i == OFF_CTRL)
        begin
            if (pwdata_i[CTRL_INT_BIT])
            begin
                s_nxt.console_interrupt_bit = 1'b0;
            end
            s_nxt.state_bit = pwdata_i[CTRL_STATE_BIT];
        end
        if (apb_wr && paddr_i == OFF_MSRC)
        begin
            s_nxt.msrc = pwdata_i[MSRC_W-1:0];
        end
        if (apb_wr && paddr_i == OFF_STAT)
        begin
            if (pwdata_i[ST_OVERRUN_BIT] &&
                !(word_done && s_r.tape_valid && !consume))
            begin
                s_nxt.overrun = 1'b0;
            end
            if (pwdata_i[ST_CORR_BIT] && !corr_set)
            begin
                s_nxt.corrected = 1'b0;
            end
        end
        // switch can only set the bit
        if (intr_press)
        begin
            s_nxt.console_interrupt_bit = 1'b1;
        end

        if (clr_press)
        begin
            s_nxt.tape_run = 1'b0;
            s_nxt.rewind = 1'b0;
            s_nxt.bit_cnt = '0;
            s_nxt.nib_cnt = '0;
            s_nxt.asm_word = '0;
            s_nxt.tape_valid = 1'b0;
            s_nxt.overrun = 1'b0;
            s_nxt.corrected = 1'b0;
        end

        // read data captured in setup phase, zero wait access
        stat[ST_RUN_BIT] = ~halted;
        stat[ST_MTR_BIT] = mtr_mode;
        stat[ST_IO_BIT] = io_mode;
        stat[ST_TAPE_BIT] = s_r.tape_run;
        stat[ST_REWIND_BIT] = s_r.rewind;
        stat[ST_LEADER_BIT] = s_r.lead_sync[1];
        stat[ST_UVALID_BIT] = s_r.tape_valid;
        stat[ST_OVERRUN_BIT] = s_r.overrun;
        stat[ST_CORR_BIT] = s_r.corrected;
        case (paddr_i)
            OFF_CTRL:
            begin
                rd[CTRL_INT_BIT] = s_r.console_interrupt_bit;
                rd[CTRL_STATE_BIT] = s_r.state_bit;
            end
            OFF_MSRC: rd[MSRC_W-1:0] = s_r.msrc;
            OFF_STAT: rd = stat;
            OFF_TAPE: rd[WORD_W-1:0] = s_r.tape_word;
            OFF_SWITCH: rd[WORD_W-1:0] = data_sw;
            default: rd = '0;
        endcase
        if (psel_i && !penable_i)
        begin
            s_nxt.prdata = rd;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
        end
        else if (clk_en_i)
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o = s_r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~cc_mapped(paddr_i);
    assign lamp_intr_o = s_r.console_interrupt_bit;
    assign lamp_test_o = s_r.console_interrupt_bit | ctl[SW_SINGLE] |
                         (panel_src != SRC_NORMAL);
    assign lamp_state_o = s_r.state_bit;
    assign lamp_run_o = ~halted;
    assign lamp_mode_o = mtr_mode;
    assign lamp_leader_o = s_r.lead_sync[1];
    assign lamp_mex_o = s_r.main_exchange_bus;
    // console actions as pseudo micro strobes
    assign run_o = ~halted;
    assign load_next_o = s_r.load_next_p;
    assign force_halt_o = s_r.force_p;
    assign clear_o = s_r.clear_p;
    assign tape_to_micro_o = s_r.to_micro_p;
    assign fetch_stall_o = mtr_mode & fetch_req_i & ~s_r.tape_valid;
    assign tape_micro_execution_mode_o = mtr_mode;
    assign micro_src_o = panel_src | s_r.msrc;
    assign tape_word_o = s_r.tape_word;
    assign tape_word_valid_o = s_r.tape_valid;
    assign console_data_o = data_sw;
    assign console_data_en_o = halted;
    assign drive_owner_io_o = io_mode;
    assign drive_run_o = io_mode ? io_run_i : s_r.tape_run;
    assign drive_rewind_o = io_mode ? io_rewind_i : s_r.rewind;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i || !clk_en_i);

    int_set_a: assert property (intr_press |=> lamp_intr_o)
        else $error("interrupt press did not set bit");
    int_hold_a: assert property ($fell(lamp_intr_o) |->
        $past(apb_wr && paddr_i == OFF_CTRL && pwdata_i[CTRL_INT_BIT]))
        else $error("interrupt bit cleared without software");
    test_lamp_a: assert property (ctl[SW_SINGLE] |-> lamp_test_o)
        else $error("test lamp dark in single step");
    halt_end_a: assert property (s_r.run == RS_STOP && micro_done_i &&
        !force_req && !mtr_mode |=> halted && load_next_o)
        else $error("halt did not load next micro");
    step_one_a: assert property (s_r.run == RS_STEP && micro_done_i
        |=> halted)
        else $error("single step did not halt");
    force_halt_a: assert property (force_req |=>
        halted && force_halt_o && !load_next_o)
        else $error("halt and clear did not force halt");
    start_run_a: assert property (halted && start_press && !force_req
        |=> !halted ##0 lamp_run_o)
        else $error("start did not leave halt");
    rewind_gate_a: assert property (s_r.tape_run |=>
        !$rose(drive_rewind_o) || io_mode)
        else $error("rewind accepted while tape moving");
    io_owner_a: assert property (io_mode |-> drive_run_o == io_run_i &&
        drive_rewind_o == io_rewind_i)
        else $error("drive not handed to io control");
    fetch_word_a: assert property (fetch_go |=>
        tape_to_micro_o && (!tape_word_valid_o || $past(word_done)))
        else $error("forced fetch did not consume word");
    data_en_a: assert property (console_data_en_o |-> !run_o)
        else $error("manual entry enabled while running");

    step_c: cover property (s_r.run == RS_STEP ##[1:50] halted);
    fetch_c: cover property (tape_to_micro_o);
    force_c: cover property (force_halt_o);
    word_c: cover property (word_done ##[1:20] tape_word_read_i);

endmodule

// ---- cc_pkg.sv ----
// constants, field positions and enumerations of the console control
// assumes a single 100 MHz clock shared by all console logic
package cc_pkg;

    localparam int CLK_MHZ = 100;
    localparam int DB_TIME_US = 10000;
    localparam int DB_CYCLES = DB_TIME_US * CLK_MHZ;
    localparam int DB_CNT_W = 20;

    localparam int WORD_W = 24;
    localparam int NIB_W = 4;
    localparam int CW_W = 7;
    localparam int SYN_W = 3;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CW_LAST = 3'h6;
    localparam logic [CNT_W-1:0] NIB_LAST = 3'h5;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MSRC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TAPE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_SWITCH = 8'h10;

    localparam int CTRL_INT_BIT = 0;
    localparam int CTRL_STATE_BIT = 3;

    localparam int MSRC_W = 2;
    localparam logic [MSRC_W-1:0] SRC_NORMAL = 2'h0;

    localparam int ST_RUN_BIT = 0;
    localparam int ST_MTR_BIT = 1;
    localparam int ST_IO_BIT = 2;
    localparam int ST_TAPE_BIT = 3;
    localparam int ST_REWIND_BIT = 4;
    localparam int ST_LEADER_BIT = 5;
    localparam int ST_UVALID_BIT = 6;
    localparam int ST_OVERRUN_BIT = 7;
    localparam int ST_CORR_BIT = 8;

    // debounced panel control vector
    localparam int BTN_INTR_OP = 0;
    localparam int BTN_INTR_DM = 1;
    localparam int BTN_CLR_OP = 2;
    localparam int BTN_CLR_DM = 3;
    localparam int BTN_START_OP = 4;
    localparam int BTN_START_DM = 5;
    localparam int BTN_HALT = 6;
    localparam int BTN_REWIND = 7;
    localparam int SW_IO = 8;
    localparam int SW_MTR = 9;
    localparam int SW_SINGLE = 10;
    localparam int SW_SRC_LO = 11;
    localparam int CTL_W = 13;

    typedef enum logic [1:0] {RS_HALT, RS_RUN, RS_STOP, RS_STEP} cc_run_t;

    // hamming(7,4): cw[0]=p1 cw[1]=p2 cw[2]=d0 cw[3]=p4 cw[4..6]=d1..d3
    function automatic logic [SYN_W-1:0] cc_syndrome(
        input logic [CW_W-1:0] cw);
        cc_syndrome = {cw[3] ^ cw[4] ^ cw[5] ^ cw[6],
                       cw[1] ^ cw[2] ^ cw[5] ^ cw[6],
                       cw[0] ^ cw[2] ^ cw[4] ^ cw[6]};
    endfunction

    function automatic logic [NIB_W-1:0] cc_fix_nibble(
        input logic [CW_W-1:0] cw);
        logic [CW_W-1:0] c;
        logic [SYN_W-1:0] s;
        c = cw;
        s = cc_syndrome(cw);
        if (s != '0)
        begin
            c[s - 3'h1] = ~c[s - 3'h1];
        end
        cc_fix_nibble = {c[6], c[5], c[4], c[2]};
    endfunction

endpackage

// ---- cc_debounce.sv ----
// two-stage synchroniser and debounce filter for a vector of panel inputs
// assumes raw_i comes straight from switches, outside the clock domain
`timescale 1ns/1ps
module cc_debounce
    import cc_pkg::*;
#(
    parameter int W = 1,
    parameter int CNT = DB_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] stable_o
);

    typedef struct packed {
        logic [W-1:0] sync1;
        logic [W-1:0] sync2;
        logic [W-1:0] stable;
        logic [DB_CNT_W-1:0] cnt;
    } cc_db_t;

    cc_db_t s_r;
    cc_db_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sync1 = raw_i;
        s_nxt.sync2 = s_r.sync1;
        // one shared counter: the vector is accepted after CNT cycles differing from stable, restarting only on a match
        if (s_r.sync2 == s_r.stable)
        begin
            s_nxt.cnt = '0;
        end
        else if (s_r.cnt == DB_CNT_W'(CNT - 1))
        begin
            s_nxt.stable = s_r.sync2;
            s_nxt.cnt = '0;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
        end
        else if (clk_en_i)
        begin
            s_r <= s_nxt;
        end
    end

    assign stable_o = s_r.stable;

endmodule

// ---- cc_panel_model.sv ----
// panels and primary cassette drive as seen by the console block
// assumes tasks are called right after a rising edge of clk_i
`timescale 1ns/1ps
module cc_panel_model
    import cc_pkg::*;
(
    input wire logic clk_i,
    output logic [CTL_W-1:0] panel_o,
    output logic tape_clk_o,
    output logic tape_bit_o,
    output logic leader_o
);
    initial
    begin
        panel_o = '0;
        tape_clk_o = 1'b0;
        tape_bit_o = 1'b0;
        leader_o = 1'b0;
    end

    // held well past the sync and debounce delay
    task automatic put(input logic [CTL_W-1:0] m, input logic [CTL_W-1:0] v);
        panel_o <= (panel_o & ~m) | (v & m);
        repeat (16) @(posedge clk_i);
    endtask

    task automatic press(input logic [CTL_W-1:0] m);
        put(m, m);
        put(m, '0);
    endtask

    task automatic lead(input logic v);
        leader_o <= v;
        repeat (5) @(posedge clk_i);
    endtask

    // nibbles top first, codeword lsb first; err picks one bit to flip
    task automatic send(input logic [WORD_W-1:0] w, input int err);
        logic [3:0] d;
        logic [6:0] c;
        for (int n = 5; n >= 0; n--)
        begin
            d = w[n*4 +: 4];
            c = {d[3:1], d[1] ^ d[2] ^ d[3], d[0],
                 d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
            for (int i = 0; i < 7; i++)
            begin
                tape_bit_o <= c[i] ^ ((5 - n) * 7 + i == err);
                repeat (2) @(posedge clk_i);
                tape_clk_o <= 1'b1;
                repeat (4) @(posedge clk_i);
                tape_clk_o <= 1'b0;
                repeat (3) @(posedge clk_i);
            end
        end
        // clock stands low between frames; data line no longer valid
        tape_bit_o <= ~tape_bit_o;
    endtask
endmodule

// ---- cc_console_test.sv ----
// self-checking bench for the console and cassette control
// assumes cc_panel_model stands in for the panels and the drive
`timescale 1ns/1ps
module cc_console_test
    import cc_pkg::*;
;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0;
    logic penable_i = 1'b0, pwrite_i = 1'b0, micro_done_i = 1'b0;
    logic cassette_control_micro_i = 1'b0, cassette_run_arg_i = 1'b0;
    logic tape_word_read_i = 1'b0, io_run_i = 1'b0, err;
    logic clk_en_i = 1'b1, fetch_req_i = 1'b0, io_rewind_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [23:0] data_sw_i = 24'h0, main_exchange_bus_i = 24'h0, v;
    logic [23:0] lamp_mex_o, tape_word_o, console_data_o;
    logic [12:0] panel_i;
    logic [1:0] micro_src_o, p, r;
    logic pready_o, pslverr_o, lamp_intr_o, lamp_test_o, lamp_leader_o;
    logic run_o, load_next_o, force_halt_o, clear_o, tape_word_valid_o;
    logic console_data_en_o, drive_owner_io_o, drive_run_o, drive_rewind_o;
    logic tape_bit_clk_i, tape_bit_i, tape_leader_detected_i;
    logic lamp_state_o, lamp_run_o, lamp_mode_o, tape_to_micro_o;
    logic fetch_stall_o, tape_micro_execution_mode_o;
    int seed = 80, bad_count = 0, n_compared = 0, n_clr = 0, n_fh = 0;
    int n_ld = 0, n_tm = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    cc_console #(.DEBOUNCE_CYCLES(4)) u_dut (.ref_clk_i, .rst_n_i,
        .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .panel_i, .data_sw_i,
        .lamp_intr_o, .lamp_test_o, .lamp_state_o, .lamp_run_o,
        .lamp_mode_o, .lamp_leader_o, .lamp_mex_o, .main_exchange_bus_i,
        .micro_done_i, .fetch_req_i, .cassette_control_micro_i,
        .cassette_run_arg_i, .tape_word_read_i, .run_o, .load_next_o,
        .force_halt_o, .clear_o, .tape_to_micro_o, .fetch_stall_o,
        .tape_micro_execution_mode_o, .micro_src_o, .tape_word_o,
        .tape_word_valid_o, .console_data_o, .console_data_en_o,
        .tape_bit_clk_i, .tape_bit_i, .tape_leader_detected_i, .io_run_i,
        .io_rewind_i, .drive_owner_io_o, .drive_run_o,
        .drive_rewind_o);

    cc_panel_model u_panel (.clk_i(ref_clk_i), .panel_o(panel_i),
        .tape_clk_o(tape_bit_clk_i), .tape_bit_o(tape_bit_i),
        .leader_o(tape_leader_detected_i));

    always @(posedge ref_clk_i)
    begin
        n_clr += clear_o;
        n_fh += force_halt_o;
        n_ld += load_next_o;
        n_tm += tape_to_micro_o;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
        if (n >= 50)
        begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic step();
        micro_done_i <= 1'b1;
        @(posedge ref_clk_i);
        micro_done_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic tape(input logic a);
        cassette_control_micro_i <= 1'b1;
        cassette_run_arg_i <= a;
        @(posedge ref_clk_i);
        cassette_control_micro_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask

    initial
    begin
        repeat (100000) @(posedge ref_clk_i);
        bad_count++;
        stop_test();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        chk(console_data_en_o, 1);
        repeat (3)
        begin
            v = $random(seed);
            main_exchange_bus_i <= v;
            repeat (2) @(posedge ref_clk_i);
            chk(lamp_mex_o, v);
        end
        clk_en_i <= 1'b0;
        main_exchange_bus_i <= ~v;
        repeat (2) @(posedge ref_clk_i);
        chk(lamp_mex_o, v);
        v = ~v;
        clk_en_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(lamp_mex_o, v);
        v = $random(seed);
        data_sw_i <= v;
        repeat (20) @(posedge ref_clk_i);
        apb(1'b0, OFF_SWITCH, 32'h0);
        chk(rd, v);
        chk(console_data_o, v);
        u_panel.press(13'h0001);
        chk(lamp_intr_o, 1);
        chk(lamp_test_o, 1);
        apb(1'b1, OFF_CTRL, 32'h1);
        chk(lamp_intr_o, 0);
        u_panel.press(13'h0002);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd[0], 1);
        apb(1'b1, OFF_CTRL, 32'h9);
        chk(lamp_intr_o, 0);
        chk(lamp_test_o, 0);
        chk(lamp_state_o, 1);
        u_panel.put(13'h0400, 13'h0400);
        chk(lamp_test_o, 1);
        u_panel.put(13'h0400, 13'h0000);
        u_panel.press(13'h0010);
        chk(run_o, 1);
        chk(lamp_run_o, 1);
        chk(console_data_en_o, 0);
        u_panel.press(13'h0040);
        chk(run_o, 1);
        step();
        chk(run_o, 0);
        chk(n_ld, 1);
        u_panel.press(13'h0020);
        chk(run_o, 1);
        u_panel.press(13'h0048);
        chk(run_o, 0);
        chk(n_fh, 1);
        chk(n_clr, 1);
        chk(n_ld, 1);
        u_panel.put(13'h0400, 13'h0400);
        u_panel.press(13'h0010);
        chk(run_o, 1);
        step();
        chk(run_o, 0);
        chk(n_ld, 2);
        u_panel.put(13'h0400, 13'h0000);
        repeat (3)
        begin
            p = $random(seed);
            r = $random(seed);
            u_panel.put(13'h1800, {p, 11'h0});
            apb(1'b1, OFF_MSRC, {30'h0, r});
            chk(micro_src_o, p | r);
            chk(lamp_test_o, p != 2'h0);
        end
        u_panel.put(13'h1800, 13'h0000);
        u_panel.put(13'h0100, 13'h0100);
        chk(drive_owner_io_o, 1);
        io_run_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(drive_run_o, 1);
        io_run_i <= 1'b0;
        io_rewind_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(drive_rewind_o, 1);
        chk(drive_run_o, 0);
        io_rewind_i <= 1'b0;
        u_panel.put(13'h0100, 13'h0000);
        chk(drive_owner_io_o, 0);
        tape(1'b1);
        chk(drive_run_o, 1);
        for (int k = 0; k < 2; k++)
        begin
            v = $random(seed);
            u_panel.send(v, k == 0 ? $unsigned($random(seed)) % 42 : -1);
            chk(tape_word_valid_o, 1);
            chk(tape_word_o, v);
            apb(1'b0, OFF_STAT, 32'h0);
            chk(rd[ST_CORR_BIT], k == 0);
            apb(1'b1, OFF_STAT, 32'h1 << ST_CORR_BIT);
            tape_word_read_i <= 1'b1;
            @(posedge ref_clk_i);
            tape_word_read_i <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
            chk(tape_word_valid_o, 0);
        end
        u_panel.press(13'h0080);
        chk(drive_rewind_o, 0);
        tape(1'b0);
        chk(drive_run_o, 0);
        u_panel.press(13'h0080);
        chk(drive_rewind_o, 1);
        u_panel.lead(1'b1);
        chk(lamp_leader_o, 1);
        chk(drive_rewind_o, 0);
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1);
        chk(rd, 0);
        u_panel.put(13'h0200, 13'h0200);
        chk(lamp_mode_o, 1);
        chk(tape_micro_execution_mode_o, 1);
        u_panel.press(13'h0010);
        chk(drive_run_o, 1);
        chk(lamp_run_o, 1);
        fetch_req_i <= 1'b1;
        @(posedge ref_clk_i);
        chk(fetch_stall_o, 1);
        v = $random(seed);
        u_panel.send(v, -1);
        chk(n_tm, 1);
        chk(tape_word_o, v);
        chk(fetch_stall_o, 1);
        fetch_req_i <= 1'b0;
        u_panel.press(13'h0040);
        step();
        chk(run_o, 0);
        chk(n_ld, 2);
        tape(1'b0);
        chk(drive_run_o, 0);
        stop_test();
    end
endmodule
